// ==== rtl/tig_gpio_irq.sv ====
/*
  tig_gpio_irq: interrupt line, reset sequencing and eight
  general-purpose pins (input, host pwm, fading output).
  Assumes the register port is driven by an i2c slave running on
  link_clk, and that sensing, mode control and memories sit outside
  and report on the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - irq held low until init completes
// - irq line updates once per scan in active and doze
// - enabled button events raise irq
// - enabled input edges raise irq
// - entering active or doze raises irq
// - compensation, shadow write, burn raise irq
// - irq asserted during every reset
// - source read or init end clears irq
// - eight pins, three modes each
// - per-pin polarity on pwm outputs
// - 8-bit pwm at 2 MHz, 256 widths
// - input pulls and debounce selectable
// - per-pin edge select, raises irq, wakes
// - host sets pwm via select and level
// - power-up loads on or off level
// - fade trigger: button or host control
// - instant or faded, linear or log
// - optional delay before fade out
// - zero times jump straight to the on or off level
// - auto-light ignores output control writes
// - step index every time times factor
module tig_gpio_irq
  import tig_pkg::*;
#(
  parameter int INIT_CYCLES       = 10000,
  parameter int STEP_UNIT_CYCLES  = 100000,
  parameter int DELAY_UNIT_CYCLES = 100000,
  parameter int DEBOUNCE_CYCLES   = 100000
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        hw_reset_n_pin,
  output logic             irq_n_pin,
  // register port on the link clock
  input  wire logic        link_clk,
  input  wire logic        link_req,
  input  wire logic        link_we,
  input  wire logic [7:0]  link_addr,
  input  wire logic [7:0]  link_wdata,
  output logic             link_ready,
  output logic             link_done,
  output logic [7:0]       link_rdata,
  // events from the sensing and mode logic
  input  wire logic        scan_tick,
  input  wire logic [1:0]  op_mode,
  input  wire logic [7:0]  button_state,
  input  wire logic [1:0]  button_event_en,
  input  wire logic        comp_done,
  input  wire logic        spm_write_done,
  input  wire logic        nvm_burn_done,
  output logic             wake_req,
  output logic             init_busy,
  // pin configuration from the shadow memory
  input  wire logic [15:0] pin_mode_sel,
  input  wire logic [15:0] pull_sel,
  input  wire logic [15:0] edge_irq_sel,
  input  wire logic [7:0]  debounce_en,
  input  wire logic [7:0]  powerup_level_sel,
  input  wire logic [7:0]  output_polarity,
  input  wire logic [63:0] on_level,
  input  wire logic [63:0] off_level,
  input  wire logic [7:0]  curve_sel,
  input  wire logic [7:0]  auto_light_en,
  input  wire logic [7:0]  rise_step_mult,
  input  wire logic [7:0]  fall_step_mult,
  input  wire logic [7:0]  rise_step_time,
  input  wire logic [7:0]  fall_step_time,
  input  wire logic [7:0]  fall_start_delay,
  // general-purpose pins
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  output logic [7:0]       pull_up_en,
  output logic [7:0]       pull_dn_en
);

  // pulse width for an intensity index
  function automatic logic [8:0] lvl_width(
    input logic [7:0] idx,
    input logic       lg
  );
    logic [17:0] sq;
    sq = 18'(({10'h000, idx} + 18'h0_0001) *
              ({10'h000, idx} + 18'h0_0001));
    if (lg)
      return sq[16:8];
    return (idx == 8'h00) ? 9'h000 : 9'({1'b0, idx} + 9'h001);
  endfunction

  // one index step toward a target
  function automatic logic [7:0] step_to(
    input logic [7:0] idx,
    input logic [7:0] tgt
  );
    return (idx < tgt) ? idx + 8'h01 : idx - 8'h01;
  endfunction

  // link domain: reset sync and request capture
  logic       lrst_s1, lrst_q;
  logic       busy_q, req_tgl_q, done_q;
  logic       ack_s1, ack_s2, ack_s3;
  logic       we_h_q;
  logic [7:0] addr_h_q, wdata_h_q, lrdata_q;
  logic       ack_tgl_q;
  logic [7:0] rdata_q;

  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= rst;
    lrst_q  <= lrst_s1;
  end

  // request held stable until the system side acknowledges
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      busy_q <= 1'b0; req_tgl_q <= 1'b0; done_q <= 1'b0;
      ack_s1 <= 1'b0; ack_s2 <= 1'b0; ack_s3 <= 1'b0;
      we_h_q <= 1'b0; addr_h_q <= 8'h00; wdata_h_q <= 8'h00;
      lrdata_q <= 8'h00;
    end
    else
    begin
      ack_s1 <= ack_tgl_q;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      done_q <= 1'b0;
      if (link_req && !busy_q)
      begin
        we_h_q    <= link_we;
        addr_h_q  <= link_addr;
        wdata_h_q <= link_wdata;
        req_tgl_q <= ~req_tgl_q;
        busy_q    <= 1'b1;
      end
      if (ack_s2 ^ ack_s3)
      begin
        busy_q   <= 1'b0;
        done_q   <= 1'b1;
        lrdata_q <= rdata_q;
      end
    end
  end

  assign link_ready = ~busy_q;
  assign link_done  = done_q;
  assign link_rdata = lrdata_q;

  // system domain: synchronisers
  logic req_s1, req_s2, req_s3;
  logic hw_s1, hw_s2;
  logic [7:0] pin_s1, pin_s2;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      req_s1 <= 1'b0; req_s2 <= 1'b0; req_s3 <= 1'b0;
      hw_s1 <= 1'b1; hw_s2 <= 1'b1;
      pin_s1 <= 8'h00; pin_s2 <= 8'h00;
    end
    else if (clk_en)
    begin
      req_s1 <= req_tgl_q; req_s2 <= req_s1; req_s3 <= req_s2;
      hw_s1 <= hw_reset_n_pin; hw_s2 <= hw_s1;
      pin_s1 <= pin_in; pin_s2 <= pin_s1;
    end
  end

  // register access decode
  wire req_evt = req_s2 ^ req_s3;
  wire wr_evt  = req_evt & we_h_q;
  wire rd_evt  = req_evt & ~we_h_q;
  wire wr_soft = wr_evt && (addr_h_q == REG_SOFT_RST);
  wire rd_src  = rd_evt && (addr_h_q == REG_IRQ_SRC);
  wire rd_inst = rd_evt && (addr_h_q == REG_IN_STAT);

  // reset sources and init sequence
  logic        soft_arm_q, soft_rst_q;
  logic [31:0] init_cnt_q;
  logic        init_q;
  wire core_rst  = rst | ~hw_s2 | soft_rst_q;
  wire init_end  = init_q && (init_cnt_q == 32'(INIT_CYCLES - 1));
  wire run       = ~core_rst & ~init_q;

  // key sequence: first value arms, second fires
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      soft_arm_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else if (clk_en && wr_soft)
    begin
      soft_arm_q <= (wdata_h_q == SOFT_KEY1);
      soft_rst_q <= soft_arm_q && (wdata_h_q == SOFT_KEY2);
    end
  end

  // init counter restarts on every reset
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      init_q     <= 1'b1;
      init_cnt_q <= 32'h0000_0000;
    end
    else if (clk_en && init_q)
    begin
      init_cnt_q <= init_cnt_q + 32'h0000_0001;
      if (init_end)
        init_q <= 1'b0;
    end
  end

  assign init_busy = init_q;

  // event detection
  logic [7:0] btn_prev_q;
  logic [1:0] mode_prev_q;
  logic [7:0] gpi_evt;
  wire [7:0] btn_touch = button_state & ~btn_prev_q;
  wire [7:0] btn_rel   = ~button_state & btn_prev_q;
  wire btn_evt = (|btn_touch & button_event_en[0]) |
                 (|btn_rel & button_event_en[1]);
  wire act_doze = (op_mode == OPM_ACTIVE) | (op_mode == OPM_DOZE);
  wire mode_evt = act_doze && (op_mode != mode_prev_q);
  wire [IRQ_W-1:0] irq_set = {
    nvm_burn_done, |gpi_evt, spm_write_done,
    btn_evt, comp_done, mode_evt
  };

  // interrupt source flags, line and input status
  logic [IRQ_W-1:0] irq_flags_q;
  logic             irq_act_q;
  logic [7:0]       in_stat_q;
  wire line_upd = act_doze ? scan_tick : 1'b1;

  always_ff @(posedge sys_clk)
  begin
    if (core_rst || init_q)
    begin
      irq_flags_q <= '0;
      in_stat_q   <= 8'h00;
      irq_act_q   <= core_rst | ~(clk_en & init_end);
      btn_prev_q  <= button_state;
      mode_prev_q <= op_mode;
    end
    else if (clk_en)
    begin
      btn_prev_q  <= button_state;
      mode_prev_q <= op_mode;
      // new events win over a same-cycle read clear
      irq_flags_q <= (rd_src ? '0 : irq_flags_q) | irq_set;
      in_stat_q   <= (rd_inst ? 8'h00 : in_stat_q) | gpi_evt;
      if (rd_src)
        irq_act_q <= 1'b0;
      else if (line_upd)
        irq_act_q <= |irq_flags_q;
    end
  end

  // pin is low while any reset or init is in progress
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      irq_n_pin <= 1'b0;
    else if (clk_en)
      irq_n_pin <= ~(irq_act_q | core_rst);
  end

  // host pwm select, levels and output control
  logic [2:0] pin_sel_q;
  logic [7:0] onoff_q;
  logic [7:0] pwm_lvl_q [NPIN];
  wire wr_pwm = wr_evt && (addr_h_q == REG_PWM_LVL);
  wire wr_ctl = wr_evt && (addr_h_q == REG_OUT_CTRL) &&
                (auto_light_en == 8'h00);

  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      pin_sel_q <= 3'h0;
      onoff_q   <= 8'h00;
    end
    else if (clk_en && run)
    begin
      if (wr_evt && addr_h_q == REG_PIN_SEL)
        pin_sel_q <= wdata_h_q[2:0];
      if (wr_ctl)
        onoff_q <= wdata_h_q;
    end
  end

  // read data captured in the same cycle the acknowledge toggles
  wire [7:0] rd_mux =
    (addr_h_q == REG_IRQ_SRC)  ? 8'(irq_flags_q) :
    (addr_h_q == REG_BTN_STAT) ? button_state :
    (addr_h_q == REG_IN_STAT)  ? in_stat_q :
    (addr_h_q == REG_OPMODE)   ? {6'h00, op_mode} :
    (addr_h_q == REG_OUT_CTRL) ? onoff_q :
    (addr_h_q == REG_PIN_SEL)  ? {5'h00, pin_sel_q} :
    (addr_h_q == REG_PWM_LVL)  ? pwm_lvl_q[pin_sel_q] :
    8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_tgl_q <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else if (clk_en && req_evt)
    begin
      rdata_q   <= run ? rd_mux : 8'h00;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // shared pwm counter at the pwm rate
  logic [7:0] pwm_div_q, pwm_cnt_q;
  logic [31:0] deb_cnt_q;
  wire pwm_tick = (pwm_div_q == 8'(PWM_DIV - 1));
  wire deb_tick = (deb_cnt_q == 32'(DEBOUNCE_CYCLES - 1));

  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      pwm_div_q <= 8'h00;
      pwm_cnt_q <= 8'h00;
      deb_cnt_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pwm_div_q <= pwm_tick ? 8'h00 : pwm_div_q + 8'h01;
      if (pwm_tick)
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
      deb_cnt_q <= deb_tick ? 32'h0000_0000 :
                   deb_cnt_q + 32'h0000_0001;
    end
  end

  // step and delay intervals in system cycles
  wire [31:0] rise_iv = 32'(rise_step_time) * 32'(rise_step_mult) *
                        32'(STEP_UNIT_CYCLES);
  wire [31:0] fall_iv = 32'(fall_step_time) * 32'(fall_step_mult) *
                        32'(STEP_UNIT_CYCLES);
  wire [31:0] hold_iv = 32'(fall_start_delay) *
                        32'(DELAY_UNIT_CYCLES);

  // per-pin logic
  logic [7:0] wake_vec;
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    wire [1:0] mode = pin_mode_sel[2*i +: 2];
    wire [7:0] lv_on  = on_level[8*i +: 8];
    wire [7:0] lv_off = off_level[8*i +: 8];
    wire is_in   = (mode != PM_HPWM) && (mode != PM_FADE);
    wire is_fade = (mode == PM_FADE);
    logic [1:0] smp_q;
    logic       deb_q, prev_q;
    tig_fade_type st_q;
    logic [7:0]  idx_q;
    logic [31:0] tmr_q;
    wire deb_val = debounce_en[i] ? deb_q : pin_s2[i];
    wire rise = deb_val & ~prev_q;
    wire fall = ~deb_val & prev_q;
    wire want = auto_light_en[i] ? button_state[i] :
                onoff_q[i];
    wire going_up = (st_q == FD_RISE);
    wire [7:0] tgt = going_up ? lv_on : lv_off;
    wire zero_t = going_up ? (rise_step_time == 8'h00) :
                  (fall_step_time == 8'h00);
    wire [31:0] reload = going_up ? rise_iv : fall_iv;
    wire [7:0] lvl = is_fade ? idx_q : pwm_lvl_q[i];
    wire act = {1'b0, pwm_cnt_q} < lvl_width(lvl, curve_sel[i]);

    assign gpi_evt[i] = is_in & ((rise & edge_irq_sel[2*i]) |
                        (fall & edge_irq_sel[2*i+1]));
    assign wake_vec[i] = gpi_evt[i];

    // debounce: three agreeing samples on the sample tick
    always_ff @(posedge sys_clk)
    begin
      if (core_rst)
      begin
        smp_q <= 2'h0; deb_q <= 1'b0; prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
        prev_q <= deb_val;
        if (deb_tick)
        begin
          smp_q <= {smp_q[0], pin_s2[i]};
          if (smp_q == {2{pin_s2[i]}})
            deb_q <= pin_s2[i];
        end
      end
    end

    // host pwm level, loaded as init ends
    always_ff @(posedge sys_clk)
    begin
      if (core_rst)
        pwm_lvl_q[i] <= 8'h00;
      else if (clk_en && init_end)
        pwm_lvl_q[i] <= powerup_level_sel[i] ? lv_on : lv_off;
      else if (clk_en && run && wr_pwm && pin_sel_q == 3'(i))
        pwm_lvl_q[i] <= wdata_h_q;
    end

    // fading state machine
    always_ff @(posedge sys_clk)
    begin
      if (core_rst || !is_fade)
      begin
        st_q <= FD_OFF; idx_q <= lv_off; tmr_q <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
        unique case (st_q)
          FD_OFF:
          begin
            idx_q <= lv_off;
            if (want)
            begin
              st_q <= FD_RISE; tmr_q <= rise_iv;
            end
          end
          FD_RISE, FD_FALL:
          begin
            if (want != going_up)
            begin
              st_q  <= going_up ? FD_HOLD : FD_RISE;
              tmr_q <= going_up ? hold_iv : rise_iv;
            end
            else if (idx_q == tgt)
              st_q <= going_up ? FD_ON : FD_OFF;
            else if (zero_t)
              idx_q <= tgt;
            else if (tmr_q == 32'h0000_0000)
            begin
              idx_q <= step_to(idx_q, tgt);
              tmr_q <= reload;
            end
            else
              tmr_q <= tmr_q - 32'h0000_0001;
          end
          FD_ON:
          begin
            idx_q <= lv_on;
            if (!want)
            begin
              st_q <= FD_HOLD; tmr_q <= hold_iv;
            end
          end
          FD_HOLD:
          begin
            if (want)
              st_q <= FD_ON;
            else if (tmr_q == 32'h0000_0000)
            begin
              st_q <= FD_FALL; tmr_q <= fall_iv;
            end
            else
              tmr_q <= tmr_q - 32'h0000_0001;
          end
        endcase
      end
    end

    // pin drive and pulls
    always_ff @(posedge sys_clk)
    begin
      if (core_rst)
      begin
        pin_out[i] <= 1'b0; pin_oe[i] <= 1'b0;
        pull_up_en[i] <= 1'b0; pull_dn_en[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        pin_out[i] <= ~is_in & (act ^ output_polarity[i]);
        pin_oe[i]  <= ~is_in;
        pull_up_en[i] <= is_in && pull_sel[2*i +: 2] == PULL_UP;
        pull_dn_en[i] <= is_in && pull_sel[2*i +: 2] == PULL_DN;
      end
    end
  end

  // wake request toward the power manager
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      wake_req <= 1'b0;
    else if (clk_en)
      wake_req <= run && (|wake_vec) && (op_mode != OPM_ACTIVE);
  end

endmodule // tig_gpio_irq
`default_nettype wire

// ==== rtl/tig_pkg.sv ====
/*
  tig_pkg: constants and types shared by the touch interrupt and
  general-purpose pin block.
  Assumes a 100 MHz system clock and 8-bit register traffic.
*/
`default_nettype none
package tig_pkg;
  // clock and pwm rate
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int PWM_CLK_HZ = 2_000_000;
  localparam int PWM_DIV    = SYS_CLK_HZ / PWM_CLK_HZ;
  localparam int NPIN       = 8;
  // register addresses
  localparam logic [7:0] REG_IRQ_SRC  = 8'h00;
  localparam logic [7:0] REG_BTN_STAT = 8'h01;
  localparam logic [7:0] REG_IN_STAT  = 8'h02;
  localparam logic [7:0] REG_OPMODE   = 8'h03;
  localparam logic [7:0] REG_OUT_CTRL = 8'h04;
  localparam logic [7:0] REG_PIN_SEL  = 8'h05;
  localparam logic [7:0] REG_PWM_LVL  = 8'h06;
  localparam logic [7:0] REG_SOFT_RST = 8'hB1;
  // soft reset key sequence
  localparam logic [7:0] SOFT_KEY1 = 8'hDE;
  localparam logic [7:0] SOFT_KEY2 = 8'h00;
  // interrupt source bit positions
  localparam int IRQ_MODE = 0;
  localparam int IRQ_COMP = 1;
  localparam int IRQ_BTN  = 2;
  localparam int IRQ_SPM  = 3;
  localparam int IRQ_GPI  = 4;
  localparam int IRQ_NVM  = 5;
  localparam int IRQ_W    = 6;
  // operation modes
  localparam logic [1:0] OPM_ACTIVE = 2'h0;
  localparam logic [1:0] OPM_DOZE   = 2'h1;
  localparam logic [1:0] OPM_SLEEP  = 2'h2;
  // pin modes
  localparam logic [1:0] PM_INPUT = 2'h0;
  localparam logic [1:0] PM_HPWM  = 2'h1;
  localparam logic [1:0] PM_FADE  = 2'h2;
  // pull selection
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  // fading output states
  typedef enum logic [2:0] {
    FD_OFF, FD_RISE, FD_ON, FD_HOLD, FD_FALL
  } tig_fade_type;
endpackage
`default_nettype wire

// ==== testbench/tig_gpio_irq_assertions.sv ====
/* port checks for tig_gpio_irq.
   assumes pins 0 and 2 keep their modes while checked. */
`timescale 1ns/1ps
`default_nettype none
module tig_chk
  import tig_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        link_clk,
  input wire logic        link_req,
  input wire logic        link_we,
  input wire logic [7:0]  link_addr,
  input wire logic        link_ready,
  input wire logic        link_done,
  input wire logic        irq_n_pin,
  input wire logic        init_busy,
  input wire logic [15:0] pin_mode_sel,
  input wire logic [15:0] pull_sel,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pull_up_en,
  input wire logic [7:0]  pull_dn_en
);
  // mode decode of the watched pins
  wire logic in0 = pin_mode_sel[1:0] inside {PM_INPUT, 2'h3};
  wire logic pw2 = pin_mode_sel[5:4] == PM_HPWM;
  wire logic take = link_req && link_ready;

  rst_irq_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !irq_n_pin) else $error("irq high after reset");
  init_irq_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    init_busy |-> !irq_n_pin) else $error("irq high during init");
  input_undriven_a: assert property (@(posedge sys_clk)
    disable iff (rst) in0 [*2] |-> !pin_oe[0])
    else $error("input pin driven");
  pwm_driven_a: assert property (@(posedge sys_clk) disable iff (rst)
    (pw2 && irq_n_pin) [*2] |-> pin_oe[2]) else $error("pwm pin undriven");
  pull_up_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in0 && pull_sel[1:0] == PULL_UP && irq_n_pin) [*2]
    |-> pull_up_en[0] && !pull_dn_en[0]) else $error("pull up wrong");
  pull_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    pw2 [*2] |-> !(pull_up_en[2] || pull_dn_en[2]))
    else $error("pull on output pin");
  take_busy_a: assert property (@(posedge link_clk) disable iff (rst)
    take |=> !link_ready) else $error("ready after take");
  done_late_a: assert property (@(posedge link_clk) disable iff (rst)
    take |-> ##[2:16] link_done) else $error("no done");
  read_clear_a: assert property (@(posedge link_clk) disable iff (rst)
    take && !link_we && link_addr == REG_IRQ_SRC |-> ##[1:20] irq_n_pin)
    else $error("irq not cleared by read");
endmodule // tig_chk

bind tig_gpio_irq tig_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .link_clk(link_clk), .link_req(link_req), .link_we(link_we),
  .link_addr(link_addr), .link_ready(link_ready), .link_done(link_done),
  .irq_n_pin(irq_n_pin), .init_busy(init_busy),
  .pin_mode_sel(pin_mode_sel), .pull_sel(pull_sel), .pin_oe(pin_oe),
  .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));
`default_nettype wire

// ==== testbench/tig_gpio_irq_tb_top.sv ====
/* testbench for tig_gpio_irq: irq sources, input edges, host pwm,
   fading output and soft reset, driven through the host model. */
`timescale 1ns/1ps
`default_nettype none
module tig_gpio_irq_tb_top
  import tig_pkg::*;
;
  logic sys_clk = 0, link_clk = 0, rst = 1, clk_en = 1, hw_reset_n_pin = 1;
  logic scan_tick = 0, comp_done = 0, spm_write_done = 0, nvm_burn_done = 0;
  logic [1:0] op_mode = OPM_ACTIVE, button_event_en = 2'h1;
  logic [7:0] button_state = 8'h00, pin_in = 8'h00, debounce_en = 8'h02;
  logic [7:0] powerup_level_sel = 8'h04, output_polarity = 8'h04;
  logic [7:0] curve_sel = 8'h00, auto_light_en = 8'h00;
  logic [7:0] fall_start_delay = 8'h00;
  logic [7:0] rise_step_mult = 8'h01, fall_step_mult = 8'h01;
  logic [7:0] rise_step_time = 8'h00, fall_step_time = 8'h00;
  logic [15:0] pin_mode_sel = 16'h0090, pull_sel = 16'h0011;
  logic [15:0] edge_irq_sel = 16'h0000;
  logic [63:0] on_level = 64'h0000_0000_FF10_0000, off_level = 64'h0;
  logic irq_n_pin, link_req, link_we, link_ready, link_done;
  logic wake_req, init_busy;
  logic [7:0] link_addr, link_wdata, link_rdata, pin_out, pin_oe;
  logic [7:0] pull_up_en, pull_dn_en;
  int errors = 0, checks = 0;
  int ev[4] = '{IRQ_MODE, IRQ_COMP, IRQ_SPM, IRQ_NVM};

  // clocks of unrelated phase
  always #5 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;

  tig_gpio_irq #(.INIT_CYCLES(20), .STEP_UNIT_CYCLES(4),
    .DELAY_UNIT_CYCLES(4), .DEBOUNCE_CYCLES(4)) uut (.sys_clk, .rst,
    .clk_en, .hw_reset_n_pin, .irq_n_pin, .link_clk, .link_req, .link_we,
    .link_addr, .link_wdata, .link_ready, .link_done, .link_rdata,
    .scan_tick, .op_mode, .button_state, .button_event_en, .comp_done,
    .spm_write_done, .nvm_burn_done, .wake_req, .init_busy,
    .pin_mode_sel, .pull_sel, .edge_irq_sel, .debounce_en,
    .powerup_level_sel, .output_polarity, .on_level, .off_level,
    .curve_sel, .auto_light_en, .rise_step_mult, .fall_step_mult,
    .rise_step_time, .fall_step_time, .fall_start_delay, .pin_in,
    .pin_out, .pin_oe, .pull_up_en, .pull_dn_en);

  tig_host host (.link_clk, .rst, .irq_n_pin, .link_ready, .link_done,
    .link_rdata, .link_req, .link_we, .link_addr, .link_wdata);

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    checks++;
    if (g != e)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic scan;
    cyc(1);
    scan_tick = 1'b1;
    cyc(1);
    scan_tick = 1'b0;
  endtask

  // scan until the irq line shows v, bounded
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 60 && irq_n_pin !== v; n++)
    begin
      scan();
      cyc(8);
    end
    chk("irq line", {7'h0, v}, {7'h0, irq_n_pin});
    if (irq_n_pin !== v) finish_test;
  endtask

  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    bit to;
    host.xfer(we, a, d, q, to);
    chk_cnt("bus timeout", 0, int'(to));
    if (to) finish_test;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
    cyc(2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask

  // pin 2 inverted: on time is low time, counted over one pwm period
  task automatic duty(input logic [7:0] l);
    int lo, hi, w;
    lo = 0;
    hi = 0;
    w = (l == 0) ? 0 : int'(l) + 1;
    wr(REG_PWM_LVL, l);
    cyc(256 * PWM_DIV);
    repeat (256 * PWM_DIV)
    begin
      cyc(1);
      if (pin_out[2] === 1'b0) lo++;
      else if (pin_out[2] === 1'b1) hi++;
    end
    chk_cnt("pwm on time", w * PWM_DIV, lo);
    chk_cnt("pwm off time", (256 - w) * PWM_DIV, hi);
  endtask

  task automatic hold(input int p, input logic v, input string nm);
    int bad;
    bad = 0;
    cyc(20);
    repeat (300)
    begin
      cyc(1);
      if (pin_out[p] !== v) bad++;
    end
    chk_cnt(nm, 0, bad);
  endtask

  // count one-cycle pulses on the wake request
  task automatic wake(input int e);
    int w;
    w = 0;
    repeat (40)
    begin
      cyc(1);
      if (wake_req === 1'b1) w++;
    end
    chk_cnt("wake pulses", e, w);
  endtask

  // main sequence
  initial
  begin
    cyc(5);
    rst = 1'b0;
    chk("irq in reset", 8'h00, {7'h0, irq_n_pin});
    cyc(10);
    chk("irq in init", 8'h00, {7'h0, irq_n_pin});
    wait_irq(1'b1);
    button_state[0] = 1'b1;
    cyc(4);
    chk("irq before scan", 8'h01, {7'h0, irq_n_pin});
    wait_irq(1'b0);
    rd(REG_BTN_STAT, 8'h01, "button status");
    rd(REG_IRQ_SRC, 8'(1 << IRQ_BTN), "irq source");
    wait_irq(1'b1);
    op_mode = OPM_SLEEP;
    cyc(4);
    for (int i = 0; i < 4; i++)
    begin
      case (i)
        0: op_mode = OPM_ACTIVE;
        1: comp_done = 1'b1;
        2: spm_write_done = 1'b1;
        default: nvm_burn_done = 1'b1;
      endcase
      cyc(1);
      {comp_done, spm_write_done, nvm_burn_done} = 3'h0;
      wait_irq(1'b0);
      rd(REG_IRQ_SRC, 8'(1 << ev[i]), "irq source");
      wait_irq(1'b1);
    end
    rd(REG_OPMODE, {6'h00, OPM_ACTIVE}, "op mode");
    edge_irq_sel = 16'h0004;
    pin_in[1] = 1'b1;
    wait_irq(1'b0);
    rd(REG_IN_STAT, 8'h02, "input status");
    rd(REG_IN_STAT, 8'h00, "input status");
    rd(REG_IRQ_SRC, 8'(1 << IRQ_GPI), "irq source");
    wait_irq(1'b1);
    pin_in[1] = 1'b0;
    repeat (6) scan();
    cyc(40);
    scan();
    chk("irq on falling", 8'h01, {7'h0, irq_n_pin});
    pin_in[1] = 1'b1;
    wake(0);
    pin_in[1] = 1'b0;
    op_mode = OPM_DOZE;
    cyc(20);
    pin_in[1] = 1'b1;
    wake(1);
    op_mode = OPM_ACTIVE;
    wr(REG_PIN_SEL, 8'h02);
    duty(8'h00);
    duty(8'h7F);
    rd(REG_PWM_LVL, 8'h7F, "pwm level");
    wr(REG_OUT_CTRL, 8'h08);
    hold(3, 1'b1, "fade on");
    wr(REG_OUT_CTRL, 8'h00);
    hold(3, 1'b0, "fade off");
    auto_light_en = 8'h08;
    wr(REG_OUT_CTRL, 8'h08);
    hold(3, 1'b0, "ctrl ignored");
    button_state[3] = 1'b1;
    hold(3, 1'b1, "auto light");
    wr(REG_SOFT_RST, SOFT_KEY1);
    wr(REG_SOFT_RST, 8'h01);
    cyc(30);
    chk("irq after bad key", 8'h01, {7'h0, irq_n_pin});
    wr(REG_SOFT_RST, SOFT_KEY1);
    wr(REG_SOFT_RST, SOFT_KEY2);
    chk("irq in soft reset", 8'h00, {7'h0, irq_n_pin});
    wait_irq(1'b1);
    rd(REG_IRQ_SRC, 8'h00, "irq source");
    hw_reset_n_pin = 1'b0;
    cyc(6);
    chk("irq in pin reset", 8'h00, {7'h0, irq_n_pin});
    hw_reset_n_pin = 1'b1;
    wait_irq(1'b1);
    wr(REG_PIN_SEL, 8'h02);
    rd(REG_PWM_LVL, 8'h10, "power-up level");
    rd(8'h40, 8'h00, "unmapped");
    finish_test;
  end
endmodule // tig_gpio_irq_tb_top
`default_nettype wire

// ==== testbench/tig_host_model.sv ====
/* host model: makes single-byte register requests on the link port.
   assumes the link clock runs free and reset comes on rst. */
`timescale 1ns/1ps
`default_nettype none
module tig_host
  import tig_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       irq_n_pin,
  input  wire logic       link_ready,
  input  wire logic       link_done,
  input  wire logic [7:0] link_rdata,
  output logic            link_req,
  output logic            link_we,
  output logic [7:0]      link_addr,
  output logic [7:0]      link_wdata
);
  logic up_q = 1'b0;
  initial {link_req, link_we, link_addr, link_wdata} = 18'h0_0000;
  // host stays silent until the irq line first rises
  always @(posedge link_clk)
    if (rst) up_q <= 1'b0;
    else if (irq_n_pin) up_q <= 1'b1;
  // one transfer; released lines show the inverse of the last value
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output bit to);
    int n;
    n = 0;
    do begin @(posedge link_clk); n++; end while (!up_q && n < 4000);
    to = !up_q;
    q = 8'h00;
    if (to) return;
    #1;
    {link_req, link_we, link_addr, link_wdata} = {1'b1, we, a, d};
    while (!link_ready && n < 8000) begin @(posedge link_clk); #1; n++; end
    @(posedge link_clk);
    #1;
    {link_req, link_we, link_addr, link_wdata} = {1'b0, ~we, ~a, ~d};
    while (!link_done && n < 8000) begin @(posedge link_clk); #1; n++; end
    q = link_rdata;
    to = n >= 8000;
  endtask
endmodule // tig_host
`default_nettype wire
